// *** core/hsb_bridge.sv ***
// Purpose: forwards host 8-bit I/O cycles to card-bus I/O cards
// Assumes: host pins asynchronous, sampled through hsb_sync
// Notes: card strobes lag the host by five edges (synchroniser plus one register); use wait if slow
`timescale 1ns/10ps
module hsb_bridge (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic                      i_ce,
  input  wire hsb_pkg::hsb_host_ctl_s    i_host_ctl,
  input  wire logic [hsb_pkg::ADDR_W-1:0] i_host_addr,
  input  wire logic [hsb_pkg::DATA_W-1:0] i_host_data,
  output logic      [hsb_pkg::DATA_W-1:0] o_host_data,
  output logic                           o_host_data_oe,
  output logic                           o_host_chrdy,
  output logic      [hsb_pkg::IRQ_N-1:0]  o_host_irq,
  input  wire logic                      i_address_width_jumper,
  input  wire logic [hsb_pkg::IRQ_N*hsb_pkg::SEL_W-1:0] i_irq_sel,
  output hsb_pkg::hsb_card_ctl_s         o_card_ctl,
  output logic      [hsb_pkg::ADDR_W-1:0] o_card_addr,
  output logic      [hsb_pkg::DATA_W-1:0] o_card_data,
  output logic                           o_card_data_oe,
  input  wire logic [hsb_pkg::DATA_W-1:0] i_card_data,
  input  wire logic                      i_card_wait_n,
  input  wire logic [hsb_pkg::SRC_N-1:0]  i_card_intrq_n,
  output logic                           o_card_sysreset_n
);
  localparam int CW = $bits(hsb_pkg::hsb_host_ctl_s);
  localparam int SW = CW + hsb_pkg::ADDR_W + hsb_pkg::DATA_W + 1
                      + hsb_pkg::SRC_N + hsb_pkg::DATA_W;
  localparam logic [CW-1:0] CTL_IDLE = 5'h1e; // strobes high, aen low

  hsb_pkg::hsb_host_ctl_s            ctl;
  logic [hsb_pkg::ADDR_W-1:0]        addr;
  logic [hsb_pkg::DATA_W-1:0]        hdata;
  logic [hsb_pkg::DATA_W-1:0]        cdata;
  logic                              wait_n;
  logic [hsb_pkg::SRC_N-1:0]         intrq_n;
  logic [SW-1:0]                     sync_out;
  hsb_pkg::hsb_cyc_e                 cyc_q;
  hsb_pkg::hsb_cyc_e                 cyc_d;
  hsb_pkg::hsb_card_ctl_s            card_q;
  logic [hsb_pkg::ADDR_W-1:0]        caddr_q;
  logic [hsb_pkg::DATA_W-1:0]        cdat_q;
  logic [hsb_pkg::DATA_W-1:0]        hdat_q;
  logic                              hoe_q;
  logic                              coe_q;
  logic                              chrdy_q;
  logic [hsb_pkg::IRQ_N-1:0]         irq_q;
  logic                              jmp_q;

  // all host and card pins except the jumpers (i_address_width_jumper, i_irq_sel) share one synchroniser bank
  hsb_sync #(
    .WIDTH (SW),
    .INIT  ({CTL_IDLE, {hsb_pkg::ADDR_W{1'b0}}, {hsb_pkg::DATA_W{1'b0}},
             1'b1, {hsb_pkg::SRC_N{1'b1}}, {hsb_pkg::DATA_W{1'b0}}})
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_async ({i_host_ctl, i_host_addr, i_host_data, i_card_wait_n,
               i_card_intrq_n, i_card_data}),
    .o_sync  (sync_out)
  );
  assign {ctl, addr, hdata, wait_n, intrq_n, cdata} = sync_out;

  // picks one card request for a host line from its jumper code
  function automatic logic irq_pick(input logic [hsb_pkg::SRC_N-1:0] req_n,
                                    input logic [hsb_pkg::SEL_W-1:0] sel);
    unique case (sel)
      hsb_pkg::SRC_INTRQ:  irq_pick = ~req_n[0];
      hsb_pkg::SRC_INTRQ1: irq_pick = ~req_n[1];
      hsb_pkg::SRC_INTRQ2: irq_pick = ~req_n[2];
      hsb_pkg::SRC_NMIRQ:  irq_pick = ~req_n[3];
    endcase
  endfunction

  // decode: memory strobes are never looked at for forwarding
  wire io_rd   = ~ctl.ior_n & ctl.iow_n;
  wire io_wr   = ~ctl.iow_n & ctl.ior_n;
  wire dma     = ctl.aen;
  wire in_win8 = (addr[9:8] == hsb_pkg::WIN8_HI);
  wire addr_ok = jmp_q ? 1'b1 : in_win8;
  wire fwd     = addr_ok & ~dma;

  // next cycle kind; a cycle ends when its strobe returns high
  always_comb begin
    cyc_d = hsb_pkg::HSB_IDLE;
    if (fwd && io_rd) begin
      cyc_d = hsb_pkg::HSB_READ;
    end else if (fwd && io_wr) begin
      cyc_d = hsb_pkg::HSB_WRITE;
    end
  end

  // jumper is static: resampled on every enabled clock after reset
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      jmp_q <= 1'b0;
    end else if (i_ce) begin
      jmp_q <= i_address_width_jumper;
    end
  end

  // cycle state and card strobes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cyc_q  <= hsb_pkg::HSB_IDLE;
      card_q <= 3'h7;
    end else if (i_ce) begin
      cyc_q         <= cyc_d;
      card_q.iorq_n <= (cyc_d == hsb_pkg::HSB_IDLE);
      card_q.rd_n   <= (cyc_d != hsb_pkg::HSB_READ);
      card_q.wr_n   <= (cyc_d != hsb_pkg::HSB_WRITE);
    end
  end

  // address and data paths; 8-bit mode still drives bits 9:8 as seen
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      caddr_q <= '0;
      cdat_q  <= '0;
      hdat_q  <= '0;
      coe_q   <= 1'b0;
      hoe_q   <= 1'b0;
    end else if (i_ce) begin
      caddr_q <= addr;
      cdat_q  <= hdata;
      hdat_q  <= cdata;
      coe_q   <= (cyc_d == hsb_pkg::HSB_WRITE);
      hoe_q   <= (cyc_d == hsb_pkg::HSB_READ);
    end
  end

  // wait and interrupts; no acknowledge path exists by design
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      chrdy_q <= 1'b1;
      irq_q   <= '0;
    end else if (i_ce) begin
      // gate on the cycle being launched, not the one ending: the synced
      // wait lags the card strobes, so a stale low must not outlive them
      chrdy_q <= wait_n | (cyc_d == hsb_pkg::HSB_IDLE);
      for (int i = 0; i < hsb_pkg::IRQ_N; i++) begin
        irq_q[i] <= irq_pick(intrq_n,
                    i_irq_sel[i*hsb_pkg::SEL_W +: hsb_pkg::SEL_W]);
      end
    end
  end

  assign o_card_ctl        = card_q;
  assign o_card_addr       = caddr_q;
  assign o_card_data       = cdat_q;
  assign o_card_data_oe    = coe_q;
  assign o_host_data       = hdat_q;
  assign o_host_data_oe    = hoe_q;
  assign o_host_chrdy      = chrdy_q;
  assign o_host_irq        = irq_q;
  assign o_card_sysreset_n = ~i_rst;
endmodule

// *** core/hsb_pkg.sv ***
// Purpose: shared constants and carriers for the host-to-card-bus I/O bridge
// Assumes: host strobes are active low pins; one 100 MHz clock
// Notes: nothing here is synthesised on its own
// Notes on behaviour
// - only host I/O reads and writes pass; memory cycles never do
// - a static jumper picks 8-bit or 10-bit card address decoding
// - in 10-bit mode all host address bits 0..9 drive the card bus
// - in 8-bit mode only host I/O addresses 100..1ff hex pass
// - card request asserts on either strobe; read follows read, write write
// - card I/O request is held off during host DMA cycles
// - five interrupt outputs drive host request lines 3 through 7
// - each host interrupt picks one of four card requests by jumper
// - no cascaded interrupt acknowledge is produced on the card bus
// - card wait requests stretch the host cycle through channel ready
// - card bus system reset follows the host reset
// - eight data bits move between host and card in strobe direction
package hsb_pkg;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int IRQ_N     = 5;
  localparam int SRC_N     = 4;
  localparam int SEL_W     = 2;
  localparam int SYNC_N    = 3;
  // window for 8-bit mode: top address bits must be 2'b01
  localparam logic [1:0] WIN8_HI = 2'h1;
  // source codes of the interrupt jumper
  localparam logic [SEL_W-1:0] SRC_INTRQ  = 2'h0;
  localparam logic [SEL_W-1:0] SRC_INTRQ1 = 2'h1;
  localparam logic [SEL_W-1:0] SRC_INTRQ2 = 2'h2;
  localparam logic [SEL_W-1:0] SRC_NMIRQ  = 2'h3;

  // host-side strobes, active low as on the pins, plus aen, which is active high
  typedef struct packed {
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic aen;
  } hsb_host_ctl_s;

  // card-side strobes, active low
  typedef struct packed {
    logic iorq_n;
    logic rd_n;
    logic wr_n;
  } hsb_card_ctl_s;

  typedef enum logic [1:0] {
    HSB_IDLE,
    HSB_READ,
    HSB_WRITE
  } hsb_cyc_e;
endpackage

// *** core/hsb_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to i_clock
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module hsb_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire  [WIDTH-1:0] out_d = (agree & s3_q) | (~agree & out_q);

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else if (i_ce) begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
  assign o_sync = out_q;
endmodule

// *** verification/hsb_bridge_bench.sv ***
// Purpose: self-checking bench for the host-to-card I/O bridge
// Assumes: i_ce tied high; a strobe is held at least ten edges before judging
// Notes: data paths go through synchronisers, so holds are generous
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module hsb_bridge_bench;
  logic                   i_clock = 1'b0;
  logic                   i_rst = 1'b1;
  hsb_pkg::hsb_host_ctl_s hc = 5'h1e;
  hsb_pkg::hsb_card_ctl_s cc;
  logic [9:0]             haddr = 10'h000, sel = 10'h000, caddr;
  logic [7:0]             hdata = 8'h00, wait_cyc = 8'h00, cdata, hrd, cwr;
  logic                   jmp = 1'b1, hoe, coe, chrdy, wait_n, srst_n;
  logic [3:0]             intrq_n = 4'hf;
  logic [4:0]             irq;
  int                     fails = 0, checks = 0;
  always #5 i_clock = ~i_clock;
  hsb_bridge u_hsb_bridge (.i_clock, .i_rst, .i_ce(1'b1), .i_host_ctl(hc),
    .i_host_addr(haddr), .i_host_data(hdata), .o_host_data(hrd),
    .o_host_data_oe(hoe), .o_host_chrdy(chrdy), .o_host_irq(irq),
    .i_address_width_jumper(jmp), .i_irq_sel(sel), .o_card_ctl(cc),
    .o_card_addr(caddr), .o_card_data(cwr), .o_card_data_oe(coe),
    .i_card_data(cdata), .i_card_wait_n(wait_n), .i_card_intrq_n(intrq_n),
    .o_card_sysreset_n(srst_n));
  hsb_card_model u_hsb_card_model (.i_clock, .i_ctl(cc), .i_addr(caddr),
    .i_wait(wait_cyc), .o_data(cdata), .o_wait_n(wait_n));
  task automatic tick(input int n); repeat (n) @(posedge i_clock); #1; endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one host cycle: w picks write, f says whether it must be forwarded
  task automatic io(input logic w, input logic [9:0] a, input logic f,
                    input int n, input logic cr);
    haddr = a; hdata = a[7:0] + 8'h11;
    if (w) hc.iow_n = 1'b0; else hc.ior_n = 1'b0;
    tick(n);
    `CHK("iorq", ~f, cc.iorq_n)
    `CHK("rd", ~(f & ~w), cc.rd_n)
    `CHK("wr", ~(f & w), cc.wr_n)
    `CHK("hoe", f & ~w, hoe)
    `CHK("coe", f & w, coe)
    `CHK("chrdy", cr, chrdy)
    if (f) `CHK("addr", a, caddr)
    if (f & ~w) `CHK("rdat", a[7:0] ^ 8'h5a, hrd)
    if (f & w) `CHK("wdat", a[7:0] + 8'h11, cwr)
    hc.ior_n = 1'b1; hc.iow_n = 1'b1;
    tick(8);
    `CHK("idle", 5'h1c, {cc, hoe, coe})
  endtask
  task automatic t_io;
    io(0, 10'h3ff, 1, 10, 1); io(1, 10'h2a5, 1, 10, 1);
    jmp = 1'b0; tick(8);
    io(0, 10'h150, 1, 10, 1); io(1, 10'h100, 1, 10, 1);
    io(0, 10'h0ff, 0, 10, 1); io(1, 10'h200, 0, 10, 1);
    jmp = 1'b1; tick(8);
    $display("t_io done");
  endtask
  task automatic t_block;
    hc.aen = 1'b1; io(0, 10'h150, 0, 10, 1); hc.aen = 1'b0;
    hc.memr_n = 1'b0; tick(10); `CHK("memr", 1'b1, cc.iorq_n)
    hc.memr_n = 1'b1; hc.memw_n = 1'b0; tick(10);
    `CHK("memw", 1'b1, cc.iorq_n)
    hc.memw_n = 1'b1; tick(8);
    $display("t_block done");
  endtask
  task automatic t_wait;
    wait_cyc = 8'd20; io(0, 10'h155, 1, 12, 0); wait_cyc = 8'h00;
    tick(20); `CHK("chrdy", 1'b1, chrdy)
    $display("t_wait done");
  endtask
  task automatic t_irq;
    sel = {2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    for (int s = 0; s < 4; s++) begin
      intrq_n = ~(4'h1 << s); tick(8);
      `CHK("irq", {s == 0, s == 3, s == 2, s == 1, s == 0}, irq)
    end
    intrq_n = 4'hf; tick(8); `CHK("irq", 5'h00, irq)
    $display("t_irq done");
  endtask
  initial begin
    #200000; fails++; finish_test;
  end
  initial begin
    tick(10); `CHK("srst", 1'b0, srst_n)
    i_rst = 1'b0; tick(1); `CHK("srst", 1'b1, srst_n)
    t_io; t_block; t_wait; t_irq;
    finish_test;
  end
endmodule

// *** verification/hsb_card_model.sv ***
// Purpose: card-bus I/O card answering reads and stretching cycles
// Assumes: strobes active low; wait length set by the bench
// Notes: released data shows the inverse of the last read value
`timescale 1ns/10ps
module hsb_card_model (
  input  wire logic                   i_clock,
  input  wire hsb_pkg::hsb_card_ctl_s i_ctl,
  input  wire logic [9:0]             i_addr,
  input  wire logic [7:0]             i_wait,
  output logic      [7:0]             o_data,
  output logic                        o_wait_n
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  // count request length so wait is dropped after i_wait cycles
  always_ff @(posedge i_clock) begin
    cnt_q <= i_ctl.iorq_n ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hff};
    if (!i_ctl.rd_n) last_q <= o_data;
  end
  assign o_wait_n = i_ctl.iorq_n || (cnt_q >= i_wait);
  assign o_data = !i_ctl.rd_n ? (i_addr[7:0] ^ 8'h5a) : ~last_q;
endmodule

// *** verification/hsb_checker.sv ***
// Purpose: protocol checker for the host-to-card I/O bridge
// Assumes: i_ce held high; card strobes lag host pins by five edges
// Notes: seven-cycle holds cover that lag before a verdict is taken
`timescale 1ns/10ps
module hsb_checker (
  input wire logic                          i_clock,
  input wire logic                          i_rst,
  input wire logic                          i_ce,
  input wire hsb_pkg::hsb_host_ctl_s        i_host_ctl,
  input wire logic [hsb_pkg::ADDR_W-1:0]    i_host_addr,
  input wire logic                          i_address_width_jumper,
  input wire hsb_pkg::hsb_card_ctl_s        o_card_ctl,
  input wire logic                          o_host_data_oe,
  input wire logic                          o_card_data_oe,
  input wire logic                          o_host_chrdy,
  input wire logic                          o_card_sysreset_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // host pin states held long enough to reach the card strobes
  sequence s_dma; (i_ce && i_host_ctl.aen)[*7]; endsequence
  sequence s_mem;
    (i_ce && !i_host_ctl.memr_n && i_host_ctl.ior_n && i_host_ctl.iow_n)[*7];
  endsequence
  sequence s_out8;
    (i_ce && !i_address_width_jumper && i_host_addr[9:8] != 2'h1)[*7];
  endsequence
  sequence s_rd;
    (i_ce && !i_host_ctl.ior_n && i_host_ctl.iow_n && i_host_ctl.memr_n &&
     !i_host_ctl.aen && i_address_width_jumper)[*7];
  endsequence
  property p_dma; s_dma |-> o_card_ctl.iorq_n; endproperty
  property p_mem; s_mem |-> o_card_ctl.iorq_n; endproperty
  property p_out8; s_out8 |-> o_card_ctl.iorq_n; endproperty
  property p_rd;
    s_rd |-> !o_card_ctl.rd_n && !o_card_ctl.iorq_n && o_card_ctl.wr_n;
  endproperty
  property p_req; !(o_card_ctl.rd_n && o_card_ctl.wr_n) |-> !o_card_ctl.iorq_n;
  endproperty
  property p_hoe; o_host_data_oe == !o_card_ctl.rd_n; endproperty
  property p_coe; o_card_data_oe == !o_card_ctl.wr_n; endproperty
  property p_chrdy; !o_host_chrdy |-> !o_card_ctl.iorq_n; endproperty
  // reset must pass through even while the bridge itself is in reset
  property p_srst; disable iff (1'b0) o_card_sysreset_n == !i_rst; endproperty
  a_dma: assert property (p_dma) else $error("card request in dma");
  a_mem: assert property (p_mem) else $error("memory cycle passed");
  a_out8: assert property (p_out8) else $error("out of window");
  a_rd: assert property (p_rd) else $error("read not forwarded");
  a_req: assert property (p_req) else $error("strobe without request");
  a_hoe: assert property (p_hoe) else $error("host drive mismatch");
  a_coe: assert property (p_coe) else $error("card drive mismatch");
  a_chrdy: assert property (p_chrdy) else $error("stray wait");
  a_srst: assert property (p_srst) else $error("card reset wrong");
endmodule
bind hsb_bridge hsb_checker u_hsb_checker (.i_clock, .i_rst, .i_ce,
  .i_host_ctl, .i_host_addr, .i_address_width_jumper, .o_card_ctl,
  .o_host_data_oe, .o_card_data_oe, .o_host_chrdy, .o_card_sysreset_n);
